// ---- include/dual_adc_params.svh ----
// Constants for the dual converter serial result output
`ifndef DUAL_ADC_PARAMS_SVH
`define DUAL_ADC_PARAMS_SVH
`define RES_W 12
`define LEAD_ZEROS 4'h2
`define WORD_CLKS 6'h0E
`define HALF_FRAME_CLKS 6'h10
`define FULL_FRAME_CLKS 6'h20
`define CNT_W 6
`define BUF_DEPTH 2
`endif

// ---- include/dual_adc_pkg.sv ----
// Types shared by the serial result output design
`default_nettype none
package dual_adc_pkg;
    typedef struct packed {
        logic [11:0] conv_a;
        logic [11:0] conv_b;
    } result_pair_s;
    typedef struct packed {
        logic frame_n;
        logic sclk;
    } link_pins_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE = 2'b10
    } frame_state_e;
endpackage
`default_nettype wire

// ---- hw/pair_buffer.sv ----
// Two-entry valid/ready buffer for result pairs
`timescale 1ns/1ps
`default_nettype none
module pair_buffer (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire dual_adc_pkg::result_pair_s wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output dual_adc_pkg::result_pair_s rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    dual_adc_pkg::result_pair_s mem_q [0:1];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic ready_q;
    logic do_wr;
    logic do_rd;

    // Handshakes; ready is kept in its own flop so the top port comes from a register
    assign do_wr = wr_valid_in && ready_q;
    assign do_rd = rd_valid_out && rd_ready_in;
    assign wr_ready_out = ready_q;
    assign rd_valid_out = (count_q != 2'h0);
    assign rd_data_out = mem_q[rd_ptr_q];

    // Storage write
    always_ff @(posedge core_clk_in) begin
        if (do_wr) begin
            mem_q[wr_ptr_q] <= wr_data_in;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
            ready_q <= 1'b1;
        end else begin
            if (do_wr) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (do_rd) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            // A write into a one-entry buffer fills it; any net read frees a slot
            if (do_wr && !do_rd) begin
                count_q <= count_q + 2'h1;
                ready_q <= (count_q == 2'h0);
            end else if (do_rd && !do_wr) begin
                count_q <= count_q - 2'h1;
                ready_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- hw/dual_adc_serial_out.sv ----
// Serial result output of a dual simultaneous-sampling converter
// Summary of operation
// - Each output bit changes on the falling edge of the host serial clock.
// - Both results appear at once, one on each data output.
// - A frame opens with two zero bits and then twelve result bits.
// - Results are shifted most significant bit first.
// - A 16-clock frame adds two trailing zero bits after the result.
// - Another 16 clocks with frame select low bring the other converter's result on the same pin.
// - The falling edge of frame select samples and starts both conversions and opens the frame.
// - The serial clock both shifts data and steps the conversion.
`timescale 1ns/1ps
`default_nettype none
`include "dual_adc_params.svh"
module dual_adc_serial_out (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic frame_n_in,
    input wire logic sclk_in,
    input wire logic [2:0] channel_pair_select_in,
    input wire dual_adc_pkg::result_pair_s sample_in,
    input wire logic sample_valid_in,
    output logic sample_ready_out,
    output logic [2:0] conv_channel_out,
    output logic conv_start_out,
    output logic sar_step_out,
    output logic dout_a_out,
    output logic dout_a_oe_out,
    output logic dout_b_out,
    output logic dout_b_oe_out
);
    // Two-flop synchronisers for the link pins
    dual_adc_pkg::link_pins_s meta_q;
    dual_adc_pkg::link_pins_s sync_q;
    dual_adc_pkg::link_pins_s prev_q;
    logic [2:0] sel_meta_q;
    logic [2:0] sel_sync_q;
    logic frame_fall;
    logic frame_rise;
    logic sclk_fall;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            meta_q <= '{frame_n: 1'b1, sclk: 1'b1};
            sync_q <= '{frame_n: 1'b1, sclk: 1'b1};
            prev_q <= '{frame_n: 1'b1, sclk: 1'b1};
            sel_meta_q <= 3'h0;
            sel_sync_q <= 3'h0;
        end else begin
            meta_q <= '{frame_n: frame_n_in, sclk: sclk_in};
            sync_q <= meta_q;
            prev_q <= sync_q;
            sel_meta_q <= channel_pair_select_in;
            sel_sync_q <= sel_meta_q;
        end
    end

    // Edge detection only on the second synchroniser stage
    assign frame_fall = prev_q.frame_n && !sync_q.frame_n;
    assign frame_rise = !prev_q.frame_n && sync_q.frame_n;
    assign sclk_fall = prev_q.sclk && !sync_q.sclk && !sync_q.frame_n;

    // Results from the converter core pass a two-entry buffer
    dual_adc_pkg::result_pair_s buf_data;
    logic buf_valid;
    logic buf_take;

    pair_buffer u_buf (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .wr_data_in(sample_in),
        .wr_valid_in(sample_valid_in),
        .wr_ready_out(sample_ready_out),
        .rd_data_out(buf_data),
        .rd_valid_out(buf_valid),
        .rd_ready_in(buf_take)
    );

    // Frame state and serial clock count
    dual_adc_pkg::frame_state_e state_q;
    logic [`CNT_W-1:0] bit_cnt_q;
    dual_adc_pkg::result_pair_s word_q;

    // A frame takes the oldest buffered pair; if none is ready, zeros go out
    assign buf_take = frame_fall && buf_valid;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            state_q <= dual_adc_pkg::ST_IDLE;
        end else begin
            case (state_q)
                dual_adc_pkg::ST_IDLE: begin
                    if (frame_fall) begin
                        state_q <= dual_adc_pkg::ST_SHIFT;
                    end
                end
                dual_adc_pkg::ST_SHIFT: begin
                    if (frame_rise) begin
                        state_q <= dual_adc_pkg::ST_IDLE;
                    end else if (sclk_fall && bit_cnt_q == `FULL_FRAME_CLKS - 6'h1) begin
                        state_q <= dual_adc_pkg::ST_DONE;
                    end
                end
                dual_adc_pkg::ST_DONE: begin
                    if (frame_rise) begin
                        state_q <= dual_adc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= dual_adc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Count falling serial clock edges within a frame
    always_ff @(posedge core_clk_in) begin
        if (srst_in || frame_fall) begin
            bit_cnt_q <= 6'h00;
        end else if (state_q == dual_adc_pkg::ST_SHIFT && sclk_fall) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
        end
    end

    // Latch the pair at frame start, both converters sampled together
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            word_q <= '0;
        end else if (frame_fall) begin
            word_q <= buf_valid ? buf_data : '0;
        end
    end

    // Bit selection: slot 0..15 own result, 16..31 the other one
    function automatic logic pick_bit(input logic [11:0] own, input logic [11:0] other,
                                      input logic [`CNT_W-1:0] cnt);
        logic [4:0] slot;
        logic [11:0] res;
        slot = cnt[4:0];
        res = cnt[4] ? other : own;
        pick_bit = 1'b0;
        if (slot[3:0] >= `LEAD_ZEROS && slot[3:0] < `WORD_CLKS) begin
            pick_bit = res[4'hD - slot[3:0]];
        end
    endfunction

    // Outputs update on each falling serial clock; the first zero appears at frame start
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            dout_a_out <= 1'b0;
            dout_b_out <= 1'b0;
            dout_a_oe_out <= 1'b0;
            dout_b_oe_out <= 1'b0;
        end else if (frame_rise || state_q == dual_adc_pkg::ST_DONE) begin
            dout_a_out <= 1'b0;
            dout_b_out <= 1'b0;
            dout_a_oe_out <= !frame_rise;
            dout_b_oe_out <= !frame_rise;
        end else if (frame_fall) begin
            dout_a_out <= 1'b0;
            dout_b_out <= 1'b0;
            dout_a_oe_out <= 1'b1;
            dout_b_oe_out <= 1'b1;
        end else if (state_q == dual_adc_pkg::ST_SHIFT && sclk_fall) begin
            // Index is count+1: the bit for the next slot, trailing zeros fall out
            dout_a_out <= pick_bit(word_q.conv_a, word_q.conv_b, bit_cnt_q + 6'h01);
            dout_b_out <= pick_bit(word_q.conv_b, word_q.conv_a, bit_cnt_q + 6'h01);
        end
    end

    // Conversion control toward the analog core
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            conv_channel_out <= 3'h0;
            conv_start_out <= 1'b0;
            sar_step_out <= 1'b0;
        end else begin
            conv_start_out <= frame_fall;
            sar_step_out <= state_q == dual_adc_pkg::ST_SHIFT && sclk_fall &&
                            bit_cnt_q < `WORD_CLKS;
            if (frame_fall) begin
                conv_channel_out <= sel_sync_q;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/dual_adc_serial_out_chk.sv ----
// Concurrent checks on the serial result output ports
`timescale 1ns/1ps
`default_nettype none
module dual_adc_serial_out_chk (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic frame_n_in,
    input wire logic sclk_in,
    input wire logic conv_start_out,
    input wire logic sar_step_out,
    input wire logic dout_a_out,
    input wire logic dout_a_oe_out,
    input wire logic dout_b_out,
    input wire logic dout_b_oe_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    // Link pins are raw here, so sync delay windows allow a cycle of slack
    idle_release_a: assert property (frame_n_in [*5] |-> !dout_a_oe_out && !sar_step_out)
        else $error("driving outside frame");
    start_after_fall_a: assert property ($fell(frame_n_in) |-> ##[2:5] conv_start_out)
        else $error("no conversion start");
    start_single_a: assert property (conv_start_out |=> !conv_start_out)
        else $error("start pulse too long");
    frame_open_a: assert property (conv_start_out |->
        dout_a_oe_out && dout_b_oe_out && !dout_a_out && !dout_b_out)
        else $error("frame does not open with zero");
    shift_on_fall_a: assert property (dout_a_oe_out && $changed(dout_a_out) |->
        !$past(sclk_in, 3) && $past(sclk_in, 7))
        else $error("data a moved off a falling edge");
    b_on_fall_a: assert property (dout_b_oe_out && $changed(dout_b_out) |-> !$past(sclk_in, 3))
        else $error("data b moved off a falling edge");
    oe_paired_a: assert property (dout_a_oe_out == dout_b_oe_out)
        else $error("pins not driven together");
    step_on_fall_a: assert property (sar_step_out |-> !$past(sclk_in, 3) ##1 !sar_step_out)
        else $error("step without serial clock fall");
endmodule
`default_nettype wire

// ---- verification/dual_adc_host.sv ----
// Host serial port model: frame select, serial clock and data capture
`timescale 1ns/1ps
`default_nettype none
module dual_adc_host (
    output logic frame_n_out,
    output logic sclk_out,
    input wire logic dout_a_in,
    input wire logic dout_a_oe_in,
    input wire logic dout_b_in,
    input wire logic dout_b_oe_in
);
    logic last_a, last_b;
    // Frame high and serial clock parked high between frames
    initial begin
        frame_n_out = 1'b1;
        sclk_out = 1'b1;
        last_a = 1'b0;
        last_b = 1'b0;
    end
    // Sample just before each fall; a released pin reads inverted so it never matches by luck
    task automatic run_frame(input int n, output logic [31:0] wa, output logic [31:0] wb);
        wa = 32'h0;
        wb = 32'h0;
        frame_n_out = 1'b0;
        #400;
        repeat (n) begin
            last_a = dout_a_oe_in ? dout_a_in : ~last_a;
            last_b = dout_b_oe_in ? dout_b_in : ~last_b;
            wa = {wa[30:0], last_a};
            wb = {wb[30:0], last_b};
            sclk_out = 1'b0;
            #200;
            sclk_out = 1'b1;
            #200;
        end
        frame_n_out = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

// ---- verification/dual_adc_serial_out_bench.sv ----
// Self-checking bench for the dual converter serial result output
`timescale 1ns/1ps
`default_nettype none
module dual_adc_serial_out_bench;
    logic core_clk_in, srst_in, frame_n, sclk, sample_valid, ready, dout_a, dout_a_oe, dout_b, dout_b_oe;
    logic conv_start, sar_step;
    logic [2:0] chan_sel, conv_channel;
    logic [31:0] wa, wb;
    dual_adc_pkg::result_pair_s pair;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_start = 0;
    int n_step = 0;
    logic [26:0] rows [3] = '{{3'h1, 24'hABC123}, {3'h6, 24'h800FFF}, {3'h3, 24'h001555}};
    dual_adc_serial_out dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .frame_n_in(frame_n), .sclk_in(sclk),
        .channel_pair_select_in(chan_sel), .sample_in(pair), .sample_valid_in(sample_valid),
        .sample_ready_out(ready), .conv_channel_out(conv_channel), .conv_start_out(conv_start),
        .sar_step_out(sar_step),
        .dout_a_out(dout_a), .dout_a_oe_out(dout_a_oe), .dout_b_out(dout_b), .dout_b_oe_out(dout_b_oe));
    dual_adc_host host (.frame_n_out(frame_n), .sclk_out(sclk), .dout_a_in(dout_a), .dout_a_oe_in(dout_a_oe),
        .dout_b_in(dout_b), .dout_b_oe_in(dout_b_oe));
    // Core clock, 50 ns period
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    // Count start and step pulses at the falling edge, where they have settled
    always @(negedge core_clk_in) begin
        if (conv_start === 1'b1) begin
            n_start++;
        end
        if (sar_step === 1'b1) begin
            n_step++;
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Slots: two zeros, result, four zeros, the other result, two zeros; shorter frames keep the head
    function automatic logic [31:0] word(input logic [11:0] a, input logic [11:0] b, input int n);
        return {2'h0, a, 4'h0, b, 2'h0} >> (32 - n);
    endfunction
    // Offer one pair; a buffer still full after 20 cycles counts a mismatch and ends the run
    task automatic push(input logic [23:0] p);
        int i;
        @(negedge core_clk_in);
        pair = p;
        sample_valid = 1'b1;
        for (i = 0; i < 20 && ready !== 1'b1; i++) @(negedge core_clk_in);
        if (i == 20) begin
            n_mismatch++;
            tally_and_finish();
        end
        @(negedge core_clk_in);
        sample_valid = 1'b0;
    endtask
    task automatic do_frame(input logic [2:0] ch, input int n, input logic [23:0] p);
        int start0;
        int step0;
        @(negedge core_clk_in);
        chan_sel = ch;
        // Select settles through its synchroniser well before the frame opens
        repeat (4) @(negedge core_clk_in);
        start0 = n_start;
        step0 = n_step;
        host.run_frame(n, wa, wb);
        cmp(n_start - start0, 32'h1);
        cmp(n_step - step0, 32'hE);
        cmp(wa, word(p[23:12], p[11:0], n));
        cmp(wb, word(p[11:0], p[23:12], n));
        cmp({29'h0, conv_channel}, {29'h0, ch});
        cmp({31'h0, dout_a_oe}, 32'h0);
    endtask
    initial begin
        srst_in = 1'b1;
        sample_valid = 1'b0;
        pair = 24'h0;
        chan_sel = 3'h0;
        repeat (4) @(negedge core_clk_in);
        srst_in = 1'b0;
        foreach (rows[i]) begin
            push(rows[i][23:0]);
            do_frame(rows[i][26:24], 32, rows[i][23:0]);
            $display("row %0d done", i);
        end
        // Two pairs fill the buffer, which must then refuse
        push(24'h5A5A5A);
        push(24'hF0F0F0);
        @(negedge core_clk_in);
        cmp({31'h0, ready}, 32'h0);
        $display("buffer full test done");
        do_frame(3'h7, 14, 24'h5A5A5A);
        do_frame(3'h2, 16, 24'hF0F0F0);
        do_frame(3'h4, 32, 24'h0);
        $display("short and empty frame tests done");
        // Reset in mid-run drops a waiting pair and clears the outputs
        push(24'h123456);
        @(negedge core_clk_in);
        srst_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
        srst_in = 1'b0;
        cmp({29'h0, conv_channel}, 32'h0);
        cmp({31'h0, ready}, 32'h1);
        cmp({30'h0, dout_a_oe, dout_b_oe}, 32'h0);
        do_frame(3'h5, 32, 24'h0);
        $display("mid-run reset test done");
        tally_and_finish();
    end
    // Watchdog against a hung run
    initial begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
bind dual_adc_serial_out dual_adc_serial_out_chk chk (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .frame_n_in(frame_n_in), .sclk_in(sclk_in), .conv_start_out(conv_start_out), .sar_step_out(sar_step_out),
    .dout_a_out(dout_a_out), .dout_a_oe_out(dout_a_oe_out), .dout_b_out(dout_b_out), .dout_b_oe_out(dout_b_oe_out));
`default_nettype wire
